// *** dv/csc_current_limits_bench.sv ***
/*
 * Self-checking bench for the current limit block.
 * Assumes the host model and checker files are compiled first.
 */
`timescale 1ns/1ns
module csc_current_limits_bench;
   // Clock, reset and stimulus levels.
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [7:0] mode = 8'h00;
   logic [15:0] temp = 16'h1B00;
   logic [15:0] iout = 16'h0000;
   logic [15:0] vsense = 16'h0000;
   logic [15:0] iinr = 16'h0000;
   logic win = 1'b0;
   logic peak = 1'b0;
   logic ramp = 1'b0;
   // Command port and results.
   wire wr, rd, rvalid, err, okp, flt, ocf, ocw;
   wire [7:0] cmd, stat;
   wire [15:0] wdata, rdata, setp, gain, iin;
   wire [2:0] step;
   integer bad_count = 0;
   integer cmp_count = 0;
   // Word defaults of the writable commands other than the setpoint and status.
   logic [7:0] codes [6] = '{8'h38, 8'h46, 8'h4A, 8'hB9, 8'hBA, 8'hF6};
   logic [15:0] dflt [6] = '{16'hBB9A, 16'hDBB8, 16'hDA80, 16'h8000,
      16'h8000, 16'h0F3C};
   always #20 clk = ~clk;
   csc_host_model csc_host_model_inst (.i_clk(clk), .o_wr(wr), .o_rd(rd),
      .o_cmd(cmd), .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid),
      .i_cmd_err(err));
   // A short model period keeps the run brief.
   csc_current_limits #(.SAMPLE_CYCLES(100)) csc_current_limits_inst (
      .i_clk(clk), .i_resetn(resetn), .i_wr(wr), .i_rd(rd), .i_cmd(cmd),
      .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_cmd_err(err), .i_switching_config(cfg),
      .i_switching_mode_setting(mode), .i_temp_ext(temp), .i_iout(iout),
      .i_vsense(vsense), .i_iin_chan_raw(iinr), .i_window_ok(win),
      .i_peak_limit(peak), .i_ramping(ramp), .o_output_ok_pin(okp),
      .o_comm_logic_fault(flt), .o_output_voltage_status(stat),
      .o_output_setpoint(setp), .o_gain_eff(gain), .o_iin_chan(iin),
      .o_oc_step(step), .o_oc_fault(ocf), .o_oc_warn(ocw));
   // Prints the verdict and stops the run.
   task end_of_test;
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Compares one value and reports a mismatch at once.
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Reads a word; a missing answer ends the run.
   task rchk(input [7:0] c, input [15:0] exp);
      logic [15:0] d;
      logic ok;
      csc_host_model_inst.rd(c, d, ok);
      if (!ok)
      begin
         bad_count++;
         $display("CHECK FAILED read %h expected answer seen none", c);
         end_of_test();
      end
      check("read word", d, exp);
   endtask
   // Main sequence.
   initial
   begin : main
      integer i;
      logic e;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      for (i = 0; i < 6; i++)
         rchk(codes[i], dflt[i]);
      check("sense gain", gain, 16'h01CD);
      @(posedge clk);
      iinr <= 16'h0900;
      repeat (250) @(posedge clk);
      check("input current", iin, 16'h04FF);
      rchk(8'hB8, 16'hE000);
      csc_host_model_inst.wr(8'h4A, 16'hD200, e);
      rchk(8'h4A, 16'hD200);
      check("oc warn", {15'h0000, ocw}, 16'h0000);
      @(posedge clk);
      iout <= 16'h1200;
      repeat (4) @(posedge clk);
      check("oc warn", {15'h0000, ocw}, 16'h0001);
      csc_host_model_inst.wr(8'hF6, 16'hF830, e);
      rchk(8'hF6, 16'hF830);
      check("logic fault", {15'h0000, flt}, 16'h0000);
      @(posedge clk);
      cfg <= 8'h40;
      rchk(8'hA5, 16'h2C00);
      csc_host_model_inst.wr(8'h21, 16'h3000, e);
      rchk(8'h21, 16'h2C00);
      check("logic fault", {15'h0000, flt}, 16'h0001);
      check("clamp warning", {15'h0000, stat[3]}, 16'h0001);
      csc_host_model_inst.wr(8'h7A, 16'h0008, e);
      check("clamp warning", {15'h0000, stat[3]}, 16'h0000);
      @(posedge clk);
      cfg <= 8'h00;
      rchk(8'hA5, 16'h5800);
      csc_host_model_inst.wr(8'h21, 16'h5000, e);
      rchk(8'h21, 16'h5000);
      csc_host_model_inst.wr(8'hA5, 16'h1234, e);
      check("refused", {15'h0000, e}, 16'h0001);
      rchk(8'hA5, 16'h5800);
      csc_host_model_inst.wr(8'hB8, 16'h1234, e);
      check("refused", {15'h0000, e}, 16'h0001);
      // Negative power drives the direct estimate below the floor.
      @(posedge clk);
      iout <= 16'hFC00;
      vsense <= 16'h0100;
      csc_host_model_inst.wr(8'hBA, 16'h0001, e);
      csc_host_model_inst.wr(8'hB9, 16'h0001, e);
      repeat (250) @(posedge clk);
      rchk(8'hB8, 16'hE000);
      // A positive direct estimate above the ceiling reads as 50.
      @(posedge clk);
      iout <= 16'h0400;
      vsense <= 16'h0F00;
      repeat (250) @(posedge clk);
      rchk(8'hB8, 16'hE320);
      // A 20 A limit is 36 mV at the default gain.
      csc_host_model_inst.wr(8'h46, 16'hDA80, e);
      repeat (10) @(posedge clk);
      check("fault step", {13'h0000, step}, 16'h0004);
      mode <= 8'h80;
      repeat (10) @(posedge clk);
      check("fault step", {13'h0000, step}, 16'h0000);
      win <= 1'b1;
      peak <= 1'b1;
      repeat (6) @(posedge clk);
      check("output ok", {15'h0000, okp}, 16'h0001);
      check("oc fault", {15'h0000, ocf}, 16'h0001);
      ramp <= 1'b1;
      win <= 1'b0;
      repeat (6) @(posedge clk);
      check("oc fault", {15'h0000, ocf}, 16'h0000);
      check("output ok", {15'h0000, okp}, 16'h0000);
      // At 77 degrees a -2000 ppm coefficient trims the gain by 10%.
      temp <= 16'h4D00;
      repeat (6) @(posedge clk);
      check("sense gain", gain, 16'h019F);
      end_of_test();
   end
endmodule

// *** dv/csc_current_limits_checker.sv ***
/*
 * Concurrent checks on the ports of the current limit block.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module csc_current_limits_checker
(
   // Clock and reset.
   input logic i_clk,
   input logic i_resetn,
   // Command port.
   input logic i_wr,
   input logic i_rd,
   input logic [7:0] i_cmd,
   input logic [15:0] i_wdata,
   input logic [15:0] o_rdata,
   input logic o_rvalid,
   input logic o_cmd_err,
   // Configuration, levels and results.
   input logic [7:0] i_switching_config,
   input logic i_window_ok,
   input logic i_peak_limit,
   input logic i_ramping,
   input logic o_output_ok_pin,
   input logic o_comm_logic_fault,
   input logic [7:0] o_output_voltage_status,
   input logic [15:0] o_output_setpoint,
   input logic o_oc_fault
);
   // Edges since reset left; synchronised levels need three of them.
   logic [2:0] up_q;
   // Highest setpoint of the voltage range now selected.
   logic [15:0] vmax;
   assign vmax = i_switching_config[6] ? 16'h2C00 : 16'h5800;
   // Saturating count keeps delayed checks clear of reset history.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_ok_follows: assert property (
      up_q >= 3'h3 |-> o_output_ok_pin == $past(i_window_ok, 3))
      else $error("output ok pin not tracking comparator");
   chk_oc_report: assert property (
      up_q >= 3'h3 |-> o_oc_fault == $past(i_peak_limit && !i_ramping, 3))
      else $error("overcurrent fault wrong");
   chk_read_answer: assert property (
      i_rd |=> o_rvalid)
      else $error("read not answered");
   chk_vmax_read: assert property (
      i_rd && i_cmd == 8'hA5 |=> o_rdata == $past(vmax))
      else $error("max voltage read wrong");
   chk_clamp_set: assert property (
      i_wr && i_cmd == 8'h21 && i_wdata > vmax |=> o_comm_logic_fault
      && o_output_setpoint == $past(vmax) && o_output_voltage_status[3])
      else $error("over range setpoint not clamped");
   chk_setpoint_take: assert property (
      i_wr && i_cmd == 8'h21 && i_wdata <= vmax
      |=> o_output_setpoint == $past(i_wdata))
      else $error("setpoint not taken");
   chk_ro_refused: assert property (
      i_wr && (i_cmd == 8'hB8 || i_cmd == 8'hA5) |=> o_cmd_err[*1]
      ##0 o_comm_logic_fault)
      else $error("read-only write not refused");
   chk_fault_sticky: assert property (
      o_comm_logic_fault |=> $stable(o_comm_logic_fault))
      else $error("logic fault cleared");
endmodule
bind csc_current_limits csc_current_limits_checker
   csc_current_limits_checker_inst (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_wr(i_wr), .i_rd(i_rd), .i_cmd(i_cmd), .i_wdata(i_wdata),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cmd_err(o_cmd_err),
   .i_switching_config(i_switching_config), .i_window_ok(i_window_ok),
   .i_peak_limit(i_peak_limit), .i_ramping(i_ramping),
   .o_output_ok_pin(o_output_ok_pin),
   .o_comm_logic_fault(o_comm_logic_fault),
   .o_output_voltage_status(o_output_voltage_status),
   .o_output_setpoint(o_output_setpoint), .o_oc_fault(o_oc_fault));

// *** dv/csc_host_model.sv ***
/*
 * Host side of the word command port: one write or read per call.
 * Assumes the block answers a read within a few cycles.
 */
`timescale 1ns/1ns
module csc_host_model
(
   // Clock.
   input logic i_clk,
   // Requests towards the block.
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [7:0] o_cmd = 8'h00,
   output logic [15:0] o_wdata = 16'h0000,
   // Answers from the block.
   input logic [15:0] i_rdata,
   input logic i_rvalid,
   input logic i_cmd_err
);
   // Words are sent whole, already in the block's linear layout.
   task wr(input [7:0] c, input [15:0] d, output e);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_cmd <= c;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_cmd <= ~c;
      o_wdata <= ~d;
      #1 e = i_cmd_err;
   endtask
   // A read waits a bounded time; released lines show the inverse.
   task rd(input [7:0] c, output [15:0] d, output ok);
      integer n;
      ok = 1'b0;
      d = 16'h0000;
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_cmd <= c;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_cmd <= ~c;
      for (n = 0; n < 4 && !ok; n++)
      begin
         #1 ok = (i_rvalid === 1'b1);
         d = i_rdata;
         if (!ok)
            @(posedge i_clk);
      end
   endtask
endmodule

// *** rtl/csc_current_limits.v ***
/*
 * Current-sense calibration, inductor self-heating model and current
 * limit handling of a step-down controller's management logic.
 * Assumes a command port already framed by the serial front end: one
 * write strobe or read strobe per two-byte word with its command code,
 * and telemetry in signed fixed point with 8 fraction bits from the ADC.
 */
`timescale 1ns/1ns
`include "csc_regs.vh"
module csc_current_limits
#(
   parameter CLK_HZ = 25000000,
   // Cycles between model updates; shorten in simulation.
   parameter SAMPLE_CYCLES = CLK_HZ / 1000 * `CSC_SAMPLE_MS
)
(
   // Clock and reset.
   input wire i_clk,
   input wire i_resetn,
   // Command port from the serial front end.
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_cmd,
   input wire [15:0] i_wdata,
   output reg [15:0] o_rdata,
   output reg o_rvalid,
   output reg o_cmd_err,
   // Configuration bytes held elsewhere.
   input wire [7:0] i_switching_config,
   input wire [7:0] i_switching_mode_setting,
   // Telemetry, signed fixed point with 8 fraction bits.
   input wire signed [15:0] i_temp_ext,
   input wire signed [15:0] i_iout,
   input wire signed [15:0] i_vsense,
   input wire signed [15:0] i_iin_chan_raw,
   // Pins and sequencing state.
   input wire i_window_ok,
   input wire i_peak_limit,
   input wire i_ramping,
   // Results.
   output reg o_output_ok_pin,
   output reg o_comm_logic_fault,
   output reg [7:0] o_output_voltage_status,
   output reg [15:0] o_output_setpoint,
   output reg signed [15:0] o_gain_eff,
   output reg signed [15:0] o_iin_chan,
   output reg [2:0] o_oc_step,
   output reg o_oc_fault,
   output reg o_oc_warn
);
   localparam F = `CSC_FRAC;

   // Registers written by the host.
   reg [15:0] sense_gain_q;
   reg [15:0] oc_fault_q;
   reg [15:0] oc_warn_q;
   reg [15:0] tau_inv_q;
   reg [15:0] theta_q;
   reg [15:0] tempco_q;
   // Self-heat estimate, signed fixed point.
   reg signed [23:0] heat_q;
   reg [31:0] tick_cnt_q;
   // Two-stage synchronisers for pin-level inputs.
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;

   // Convert a signed_exp_mantissa_format word to signed fixed point with F fraction
   // bits; the exponent and mantissa are both two's complement.
   function signed [31:0] lin2fx;
      input [15:0] w;
      reg signed [4:0] e;
      reg signed [31:0] m;
      begin
         e = w[`CSC_EXP_MSB:`CSC_EXP_LSB];
         m = {{21{w[`CSC_MAN_MSB]}}, w[`CSC_MAN_MSB:0]} <<< F;
         if (e < 0)
         begin
            lin2fx = m >>> (-e);
         end
         else
         begin
            lin2fx = m <<< e;
         end
      end
   endfunction

   // Pin levels cross into the clock domain before use; the window and
   // the peak-limit flag come from analog comparators.
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end
      else
      begin
         sync1_q <= {i_ramping, i_peak_limit, i_window_ok};
         sync2_q <= sync1_q;
      end
   end

   // Effective gain: gain * (1 + tc*1e-6*(T-27)). The ppm product is
   // divided by one million exactly; a power-of-two shift is cheaper
   // but drifts by almost five percent of the correction.
   wire signed [31:0] gain_fx = lin2fx(sense_gain_q);
   wire signed [31:0] dtemp = (i_temp_ext >>> F) - `CSC_T_NOMINAL;
   wire signed [47:0] tc_prod = $signed(tempco_q) * dtemp;
   wire signed [63:0] gain_adj = gain_fx * tc_prod;
   // Correction in gain units; it always fits the lower 32 bits.
   wire signed [63:0] gain_corr = gain_adj / 64'sh0F4240;
   wire signed [31:0] gain_eff = gain_fx + $signed(gain_corr[31:0]);
   wire signed [31:0] gain_den = (gain_eff > 0) ? gain_eff : 32'sd1;

   // Sense voltages of the limit steps in uV, chosen by range.
   wire hi_range = i_switching_mode_setting[`CSC_MODE_HI_CUR_BIT];
   wire signed [31:0] step_base = hi_range ? 32'sd37500 : 32'sd25000;
   wire signed [31:0] step_inc = hi_range ? 32'sd5357 : 32'sd3571;
   // Requested limit as sense voltage in uV: amps times milliohms gives
   // millivolts with 2F fraction bits, scaled here to whole microvolts.
   wire signed [63:0] req_uv = (lin2fx(oc_fault_q) * gain_eff * 64'sh3E8)
                               >>> (2 * F);
   reg [2:0] step_d;
   integer k;
   // Pick the smallest step whose voltage is not below the request.
   always @*
   begin
      step_d = 3'h7;
      for (k = 7; k >= 0; k = k - 1)
      begin
         if (step_base + k * step_inc >= req_uv)
         begin
            step_d = k[2:0];
         end
      end
   end

   // Warning compares the output current against the warn limit, with
   // the gain applied to the raw sense measurement.
   // The sign casts keep the division signed for negative currents.
   wire signed [63:0] iout_cal = ($signed(i_iout) <<< (2 * F))
                                 / gain_den;
   wire signed [31:0] warn_fx = lin2fx(oc_warn_q);
   wire signed [63:0] iin_cal = ($signed(i_iin_chan_raw) <<< (2 * F))
                                / gain_den;
   // Calibrated channel current back at F fraction bits.
   wire signed [63:0] iin_fx = iin_cal >>> F;

   // Self-heating model terms.
   wire signed [31:0] tau_fx = lin2fx(tau_inv_q);
   wire signed [31:0] th_fx = lin2fx(theta_q);
   wire t_ok = (i_temp_ext >>> F) >= `CSC_T_SENSOR_MIN &&
               (i_temp_ext >>> F) <= `CSC_T_SENSOR_MAX;
   wire signed [31:0] ts = t_ok ? i_temp_ext
                               : (`CSC_T_SENSOR_MIN <<< F);
   wire signed [31:0] p_in = (i_iout * i_vsense) >>> F;
   wire signed [63:0] p_th = (p_in * th_fx) >>> F;
   wire signed [63:0] t_ind = heat_q + ts;
   wire signed [63:0] dheat = ((p_th - t_ind) * tau_fx) >>> F;
   wire signed [63:0] heat_sum = heat_q + dheat;

   // Setpoint limit in the output format exponent.
   wire [15:0] vmax = i_switching_config[`CSC_CFG_LOW_RANGE_BIT] ?
                      `CSC_VMAX_LOW : `CSC_VMAX_HIGH;

   // Register writes, model update and fault flags.
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sense_gain_q <= `CSC_RST_SENSE_GAIN;
         oc_fault_q <= `CSC_RST_OC_FAULT;
         oc_warn_q <= `CSC_RST_OC_WARN;
         tau_inv_q <= `CSC_RST_TAU_INV;
         theta_q <= `CSC_RST_THETA;
         tempco_q <= `CSC_RST_TEMPCO;
         heat_q <= 24'sh0;
         tick_cnt_q <= 32'h0;
         o_output_setpoint <= `CSC_RST_SETPOINT;
         o_comm_logic_fault <= 1'b0;
         o_output_voltage_status <= 8'h00;
         o_cmd_err <= 1'b0;
      end
      else
      begin
         o_cmd_err <= 1'b0;
         if (i_wr)
         begin
            // Writes land by command code; read-only words refuse.
            case (i_cmd)
               `CSC_CMD_SENSE_GAIN: sense_gain_q <= i_wdata;
               `CSC_CMD_OC_FAULT: oc_fault_q <= i_wdata;
               `CSC_CMD_OC_WARN: oc_warn_q <= i_wdata;
               `CSC_CMD_TAU_INV: tau_inv_q <= i_wdata;
               `CSC_CMD_THETA: theta_q <= i_wdata;
               `CSC_CMD_TEMPCO: tempco_q <= i_wdata;
               `CSC_CMD_SETPOINT:
               begin
                  if (i_wdata > vmax)
                  begin
                     o_output_setpoint <= vmax;
                     o_comm_logic_fault <= 1'b1;
                     o_output_voltage_status[`CSC_STAT_CLAMP_BIT]
                        <= 1'b1;
                  end
                  else
                  begin
                     o_output_setpoint <= i_wdata;
                  end
               end
               `CSC_CMD_VOUT_STATUS:
               begin
                  // Write one to clear status bits.
                  o_output_voltage_status <=
                     o_output_voltage_status & ~i_wdata[7:0];
               end
               default:
               begin
                  // Read-only or unknown code: flag a command fault.
                  o_comm_logic_fault <= 1'b1;
                  o_cmd_err <= 1'b1;
               end
            endcase
         end
         // Model runs once per sample period.
         if (tick_cnt_q >= SAMPLE_CYCLES - 1)
         begin
            tick_cnt_q <= 32'h0;
            if (th_fx <= 0 || tau_fx <= 0)
            begin
               heat_q <= 24'sh0;
            end
            else if (tau_fx >= (32'sd1 <<< F))
            begin
               heat_q <= p_th[23:0];
            end
            else
            begin
               heat_q <= heat_sum[23:0];
            end
         end
         else
         begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
         end
      end
   end

   // Reported self-heat, clamped to 0..50 degrees.
   localparam signed [23:0] HEAT_MAX_FX = `CSC_T_HEAT_MAX <<< F;
   wire signed [23:0] heat_rep =
      (heat_q < 0) ? 24'sh0 :
      (heat_q > HEAT_MAX_FX) ? HEAT_MAX_FX :
      heat_q;

   // Outputs straight from flip-flops; reads answer one cycle later.
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         o_output_ok_pin <= 1'b0;
         o_gain_eff <= 16'sh0;
         o_iin_chan <= 16'sh0;
         o_oc_step <= 3'h0;
         o_oc_fault <= 1'b0;
         o_oc_warn <= 1'b0;
      end
      else
      begin
         o_rvalid <= i_rd;
         o_output_ok_pin <= sync2_q[0];
         o_gain_eff <= gain_eff[15:0];
         o_iin_chan <= iin_fx[15:0];
         o_oc_step <= step_d;
         o_oc_fault <= sync2_q[1] && !sync2_q[2];
         o_oc_warn <= (iout_cal >>> F) > warn_fx;
         if (i_rd)
         begin
            case (i_cmd)
               `CSC_CMD_SENSE_GAIN: o_rdata <= sense_gain_q;
               `CSC_CMD_OC_FAULT: o_rdata <= oc_fault_q;
               `CSC_CMD_OC_WARN: o_rdata <= oc_warn_q;
               // Self-heat as a linear word with exponent -4: 50
               // degrees needs 800 counts, which an 11-bit mantissa
               // holds, while a finer exponent would overflow.
               `CSC_CMD_SELF_HEAT:
                  o_rdata <= {5'h1C, heat_rep[F+6:F-4]};
               `CSC_CMD_TAU_INV: o_rdata <= tau_inv_q;
               `CSC_CMD_THETA: o_rdata <= theta_q;
               `CSC_CMD_TEMPCO: o_rdata <= tempco_q;
               `CSC_CMD_VOUT_MAX: o_rdata <= vmax;
               `CSC_CMD_SETPOINT: o_rdata <= o_output_setpoint;
               `CSC_CMD_VOUT_STATUS:
                  o_rdata <= {8'h00, o_output_voltage_status};
               `CSC_CMD_FORMAT_BYTE:
                  o_rdata <= {8'h00, `CSC_FORMAT_BYTE};
               default: o_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule

// *** rtl/csc_regs.vh ***
/*
 * Command codes, reset values, field positions and timing figures for the
 * current-sense calibration and limit block.
 * Assumes it is included by bare name into the block's design file.
 */
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
// Command codes of the two-byte words held or reported here.
`define CSC_CMD_SENSE_GAIN 8'h38
`define CSC_CMD_OC_FAULT 8'h46
`define CSC_CMD_OC_WARN 8'h4A
`define CSC_CMD_SELF_HEAT 8'hB8
`define CSC_CMD_TAU_INV 8'hB9
`define CSC_CMD_THETA 8'hBA
`define CSC_CMD_TEMPCO 8'hF6
`define CSC_CMD_VOUT_MAX 8'hA5
`define CSC_CMD_SETPOINT 8'h21
`define CSC_CMD_VOUT_STATUS 8'h7A
`define CSC_CMD_FORMAT_BYTE 8'h20
// Reset values.
`define CSC_RST_SENSE_GAIN 16'hBB9A
`define CSC_RST_OC_FAULT 16'hDBB8
`define CSC_RST_OC_WARN 16'hDA80
`define CSC_RST_TAU_INV 16'h8000
`define CSC_RST_THETA 16'h8000
`define CSC_RST_TEMPCO 16'h0F3C
`define CSC_RST_SETPOINT 16'h1000
// Output format byte: mode 3 bits (linear), exponent 5 bits (-12).
`define CSC_FORMAT_BYTE 8'h14
// Maximum producible voltage, unsigned linear, exponent -12.
`define CSC_VMAX_HIGH 16'h5800
`define CSC_VMAX_LOW 16'h2C00
// Field positions.
`define CSC_CFG_LOW_RANGE_BIT 6
`define CSC_MODE_HI_CUR_BIT 7
`define CSC_STAT_CLAMP_BIT 3
// Signed_exp_mantissa_format field layout.
`define CSC_EXP_MSB 15
`define CSC_EXP_LSB 11
`define CSC_MAN_MSB 10
// Temperature model figures, whole degrees Celsius.
`define CSC_T_NOMINAL 16'sh001B
`define CSC_T_SENSOR_MIN 16'shFFCE
`define CSC_T_SENSOR_MAX 16'sh0096
`define CSC_T_HEAT_MAX 16'sh0032
// Model update period in milliseconds.
`define CSC_SAMPLE_MS 1000
// Fractional bits of internal fixed point values.
`define CSC_FRAC 8
`endif
